// ### pkg/sfc_pkg.sv
// constants and helpers for port flow control
package sfc_pkg;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_THRESH = 8'h04;
    localparam logic [7:0] A_PT10 = 8'h08;
    localparam logic [7:0] A_PT100 = 8'h0C;
    localparam logic [7:0] A_NODE_LO = 8'h10;
    localparam logic [7:0] A_NODE_HI = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_CTRL_CNT = 8'h1C;
    // ctrl bits
    localparam int B_FLOW = 0;
    localparam int B_PAUSE = 1;
    localparam int B_PAUSETX = 2;
    localparam int B_FDX = 3;
    localparam int B_SPD100 = 4;
    localparam int B_REQN = 5;
    localparam int B_REQN_TX = 6;
    localparam int B_REQN_RX = 7;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RST = 8'hE0;
    // frame layout
    localparam logic [47:0] PAUSE_DA = 48'h0180C2000001;
    localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam int HDR_BYTES = 18;
    localparam int HDR_W = 144;
    localparam int OFF_SA = 6;
    localparam logic [6:0] FRAME_BYTES = 7'h40;
    localparam logic [6:0] DATA_BYTES = 7'h3C;
    localparam logic [10:0] MIN_RX_LEN = 11'h040;
    localparam logic [10:0] MAX_RX_LEN = 11'h5FB;
    localparam logic [10:0] LEN_SAT = 11'h7FF;
    // crc
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    // a quantum is 512 bit times
    localparam int QUANTUM_BITS = 512;
    localparam logic [6:0] QUANTUM_BYTES = 7'(QUANTUM_BITS / 8);
    localparam int RESEND_DIV = 5;

    typedef enum logic [1:0] {TXS_IDLE = 2'b00, TXS_WAIT = 2'b01, TXS_SEND = 2'b11} sfc_txs_e;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] x;
        x = c ^ {24'h000000, b};
        for (int k = 0; k < 8; k++)
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        return x;
    endfunction
endpackage

// ### verilog/sfc_sync3.sv
// three-flop synchroniser, stages two and three must agree
`timescale 1ns/1ps
`default_nettype none
module sfc_sync3 #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q <= '0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                q <= s3_r;
        end
    end
endmodule
`default_nettype wire

// ### verilog/sfc_pause_gen.sv
// emits one 64-byte pause frame, a byte per link cycle
`timescale 1ns/1ps
`default_nettype none
module sfc_pause_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic byte_en,
    input wire logic [47:0] src_addr,
    input wire logic [15:0] pause_time,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic busy
);
    logic [6:0] idx_r;
    logic [31:0] crc_r;
    logic [47:0] sa_r;
    logic [15:0] pt_r;

    // header bytes, msb byte first
    function automatic logic [7:0] hdr_byte(input logic [6:0] i, input logic [47:0] sa,
                                            input logic [15:0] pt);
        logic [sfc_pkg::HDR_W-1:0] h;
        h = {sfc_pkg::PAUSE_DA, sa, sfc_pkg::MAC_CTRL_TYPE, sfc_pkg::PAUSE_OPCODE, pt};
        if (int'(i) < sfc_pkg::HDR_BYTES)
            return h[sfc_pkg::HDR_W - 1 - 8 * int'(i) -: 8];
        return 8'h00;
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idx_r <= 7'h00;
            crc_r <= sfc_pkg::CRC_INIT;
            sa_r <= 48'h000000000000;
            pt_r <= 16'h0000;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            busy <= 1'b0;
        end
        else if (!busy)
        begin
            if (start)
            begin
                busy <= 1'b1;
                idx_r <= 7'h00;
                crc_r <= sfc_pkg::CRC_INIT;
                sa_r <= src_addr;
                pt_r <= pause_time;
            end
        end
        else if (byte_en)
        begin
            if (idx_r == sfc_pkg::FRAME_BYTES)
            begin
                tx_valid <= 1'b0;
                busy <= 1'b0;
            end
            else if (idx_r < sfc_pkg::DATA_BYTES)
            begin
                tx_data <= hdr_byte(idx_r, sa_r, pt_r);
                crc_r <= sfc_pkg::crc_byte(crc_r, hdr_byte(idx_r, sa_r, pt_r));
                tx_valid <= 1'b1;
                idx_r <= idx_r + 7'h01;
            end
            else
            begin
                // fcs, low byte first
                tx_data <= ~crc_r[7:0];
                crc_r <= crc_r >> 8;
                idx_r <= idx_r + 7'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### verilog/sfc_flow_ctl.sv
// per-port congestion and pause flow control with apb registers
// What this block does
// - flow control while free buffers below threshold
// - reset threshold fits one max frame per port
// - full duplex: collision blocks new frame start
// - forced collisions unlimited, no backoff
// - pause frame: reserved multicast DA, node SA
// - then type 8808, opcode 1, pause time
// - pause time in quanta, sent value nonzero
// - fields msb byte first, lsb bit first
// - pause frames exactly 64 bytes with fcs
// - send only if pause, full duplex, flow
// - honour pause if either enable bit set
// - drop all mac control frames, count them
// - pause valid: opcode, enable, length, error, crc
// - load pause time into timer and run
// - during pause: expire on foreign DA/zero
// - clearing both pause enable bits expires the timer
// - paused port starts no new data frame
// - own pause frames still sent while paused
// - active-low pause negotiation request bits
// - send pause at once or after frame
// - resend after 80 percent of interval
`timescale 1ns/1ps
`default_nettype none
module sfc_flow_ctl #(
    parameter int FB_W = 12,
    parameter int NUM_PORTS = 27,
    parameter int MAX_FRAME_BUFS = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [FB_W-1:0] free_buffers,
    input wire logic link_clk,
    input wire logic rx_dv,
    input wire logic [7:0] rx_data,
    input wire logic port_receive_error,
    input wire logic col,
    input wire logic mac_tx_busy,
    output logic tx_start_ok,
    output logic force_col,
    output logic [7:0] pfr_data,
    output logic pfr_valid,
    output logic rx_ctrl_drop,
    output logic pause_req_n,
    output logic txp_req_n,
    output logic rxp_req_n,
    output logic paused
);
    localparam logic [FB_W-1:0] RST_THRESH = FB_W'(NUM_PORTS * MAX_FRAME_BUFS);

    logic [sfc_pkg::CTRL_W-1:0] ctrl_r;
    logic [FB_W-1:0] thresh_r;
    logic [15:0] pt10_r;
    logic [15:0] pt100_r;
    logic [47:0] node_r;
    logic [31:0] ctrl_cnt_r;
    logic congested_r;
    logic [15:0] timer_r;
    logic [6:0] qcnt_r;
    logic qtick_r;
    logic [15:0] elapsed_r;
    logic sent_once_r;
    logic gen_start_r;
    logic gen_busy;
    sfc_pkg::sfc_txs_e txs_r;
    logic [11:0] pin_q;
    logic lk_prev_r;
    logic dv_prev_r;
    logic [10:0] rlen_r;
    logic [sfc_pkg::HDR_W-1:0] hdr_r;
    logic [31:0] rcrc_r;
    logic rerr_r;
    logic apb_acc;
    logic [31:0] rdata;
    logic rd_ok;

    wire link_rise = pin_q[0] & ~lk_prev_r;
    wire dv_q = pin_q[1];
    wire [7:0] rxd_q = pin_q[9:2];
    wire rxer_q = pin_q[10];
    wire col_q = pin_q[11];
    wire frame_start = dv_q & ~dv_prev_r;
    wire frame_end = dv_prev_r & ~dv_q;
    wire rx_byte = link_rise & dv_q;
    wire fdx = ctrl_r[sfc_pkg::B_FDX];
    wire honour = ctrl_r[sfc_pkg::B_PAUSE] | ctrl_r[sfc_pkg::B_PAUSETX];
    wire can_send = ctrl_r[sfc_pkg::B_FLOW] & ctrl_r[sfc_pkg::B_PAUSE] & fdx;
    wire [15:0] pt_sel = ctrl_r[sfc_pkg::B_SPD100] ? pt100_r : pt10_r;
    wire [15:0] resend_at = pt_sel - 16'(pt_sel / sfc_pkg::RESEND_DIV);

    // rx header fields
    wire [47:0] rx_da = hdr_r[143:96];
    wire [15:0] rx_type = hdr_r[47:32];
    wire [15:0] rx_opc = hdr_r[31:16];
    wire [15:0] rx_pt = hdr_r[15:0];
    wire rx_is_ctrl = rx_type == sfc_pkg::MAC_CTRL_TYPE;
    wire rx_da_ok = (rx_da == sfc_pkg::PAUSE_DA) || (rx_da == node_r);
    wire rx_pause_ok = rx_is_ctrl && rx_opc == sfc_pkg::PAUSE_OPCODE && honour
        && rlen_r >= sfc_pkg::MIN_RX_LEN && rlen_r <= sfc_pkg::MAX_RX_LEN
        && !rerr_r && rcrc_r == sfc_pkg::CRC_RESIDUE;

    sfc_sync3 #(
        .W(12)
    ) u_pins (
        .pclk(pclk),
        .presetn(presetn),
        .d({col, port_receive_error, rx_data, rx_dv, link_clk}),
        .q(pin_q)
    );

    sfc_pause_gen u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .start(gen_start_r),
        .byte_en(link_rise),
        .src_addr(node_r),
        .pause_time(pt_sel),
        .tx_data(pfr_data),
        .tx_valid(pfr_valid),
        .busy(gen_busy)
    );

    // apb: one wait state
    assign apb_acc = psel & penable & pready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel & penable & ~pready;
    end

    always_comb
    begin
        rdata = 32'h00000000;
        rd_ok = 1'b1;
        case (paddr)
            sfc_pkg::A_CTRL: rdata[sfc_pkg::CTRL_W-1:0] = ctrl_r;
            sfc_pkg::A_THRESH: rdata[FB_W-1:0] = thresh_r;
            sfc_pkg::A_PT10: rdata[15:0] = pt10_r;
            sfc_pkg::A_PT100: rdata[15:0] = pt100_r;
            sfc_pkg::A_NODE_LO: rdata = node_r[31:0];
            sfc_pkg::A_NODE_HI: rdata[15:0] = node_r[47:32];
            sfc_pkg::A_STATUS: rdata = {timer_r, 10'h000, txs_r, gen_busy, sent_once_r,
                                        timer_r != 16'h0000, congested_r};
            sfc_pkg::A_CTRL_CNT: rdata = ctrl_cnt_r;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (psel & penable & ~pready)
        begin
            prdata <= pwrite ? 32'h00000000 : rdata;
            pslverr <= ~rd_ok;
        end
        else
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= sfc_pkg::CTRL_RST;
            thresh_r <= RST_THRESH;
            pt10_r <= 16'h0000;
            pt100_r <= 16'h0000;
            node_r <= 48'h000000000000;
        end
        else if (apb_acc & pwrite)
        begin
            case (paddr)
                sfc_pkg::A_CTRL: ctrl_r <= pwdata[sfc_pkg::CTRL_W-1:0];
                sfc_pkg::A_THRESH: thresh_r <= pwdata[FB_W-1:0];
                sfc_pkg::A_PT10: pt10_r <= pwdata[15:0];
                sfc_pkg::A_PT100: pt100_r <= pwdata[15:0];
                sfc_pkg::A_NODE_LO: node_r[31:0] <= pwdata;
                sfc_pkg::A_NODE_HI: node_r[47:32] <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // negotiation requests to the phy
    assign pause_req_n = ctrl_r[sfc_pkg::B_REQN];
    assign txp_req_n = ctrl_r[sfc_pkg::B_REQN_TX];
    assign rxp_req_n = ctrl_r[sfc_pkg::B_REQN_RX];

    // congestion; equal holds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            congested_r <= 1'b0;
        else if (free_buffers < thresh_r)
            congested_r <= 1'b1;
        else if (free_buffers > thresh_r)
            congested_r <= 1'b0;
    end

    // half duplex: jam while congested, no limit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            force_col <= 1'b0;
        else
            force_col <= congested_r & ctrl_r[sfc_pkg::B_FLOW] & ~fdx;
    end

    // link edges and quantum tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lk_prev_r <= 1'b0;
            dv_prev_r <= 1'b0;
            qcnt_r <= 7'h00;
            qtick_r <= 1'b0;
        end
        else
        begin
            lk_prev_r <= pin_q[0];
            dv_prev_r <= dv_q;
            qtick_r <= 1'b0;
            if (link_rise)
            begin
                if (qcnt_r == sfc_pkg::QUANTUM_BYTES - 7'h01)
                begin
                    qcnt_r <= 7'h00;
                    qtick_r <= 1'b1;
                end
                else
                    qcnt_r <= qcnt_r + 7'h01;
            end
        end
    end

    // receive parser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rlen_r <= 11'h000;
            hdr_r <= '0;
            rcrc_r <= sfc_pkg::CRC_INIT;
            rerr_r <= 1'b0;
        end
        else if (frame_start)
        begin
            rlen_r <= 11'h000;
            rcrc_r <= sfc_pkg::CRC_INIT;
            rerr_r <= rxer_q;
        end
        else
        begin
            if (dv_q & rxer_q)
                rerr_r <= 1'b1;
            if (rx_byte)
            begin
                if (rlen_r != sfc_pkg::LEN_SAT)
                    rlen_r <= rlen_r + 11'h001;
                if (int'(rlen_r) < sfc_pkg::HDR_BYTES)
                    hdr_r <= {hdr_r[sfc_pkg::HDR_W-9:0], rxd_q};
                rcrc_r <= sfc_pkg::crc_byte(rcrc_r, rxd_q);
            end
        end
    end

    // drop and count mac control frames
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_ctrl_drop <= 1'b0;
            ctrl_cnt_r <= 32'h00000000;
        end
        else
        begin
            if (frame_start)
                rx_ctrl_drop <= 1'b0;
            else if (dv_q && int'(rlen_r) >= sfc_pkg::HDR_BYTES)
                rx_ctrl_drop <= rx_is_ctrl;
            else if (!dv_q)
                rx_ctrl_drop <= 1'b0;
            if (frame_end && rx_is_ctrl && int'(rlen_r) >= sfc_pkg::HDR_BYTES)
                ctrl_cnt_r <= ctrl_cnt_r + 32'h00000001;
        end
    end

    // pause timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_r <= 16'h0000;
        else if (!honour)
            timer_r <= 16'h0000;
        else if (frame_end && rx_pause_ok)
        begin
            if (timer_r != 16'h0000 && (!rx_da_ok || rx_pt == 16'h0000))
                timer_r <= 16'h0000;
            else
                timer_r <= rx_pt;
        end
        else if (qtick_r && timer_r != 16'h0000)
            timer_r <= timer_r - 16'h0001;
    end

    // pause transmit scheduling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txs_r <= sfc_pkg::TXS_IDLE;
            gen_start_r <= 1'b0;
            sent_once_r <= 1'b0;
            elapsed_r <= 16'h0000;
        end
        else
        begin
            gen_start_r <= 1'b0;
            if (qtick_r && elapsed_r != 16'hFFFF)
                elapsed_r <= elapsed_r + 16'h0001;
            if (!congested_r)
                sent_once_r <= 1'b0;
            case (txs_r)
                sfc_pkg::TXS_IDLE:
                begin
                    // zero pause time sends nothing
                    if (can_send && congested_r && pt_sel != 16'h0000
                        && (!sent_once_r || elapsed_r >= resend_at))
                        txs_r <= sfc_pkg::TXS_WAIT;
                end
                sfc_pkg::TXS_WAIT:
                begin
                    // not gated by the pause timer
                    if (!mac_tx_busy && !col_q)
                    begin
                        gen_start_r <= 1'b1;
                        txs_r <= sfc_pkg::TXS_SEND;
                    end
                end
                sfc_pkg::TXS_SEND:
                begin
                    if (!gen_busy && !gen_start_r)
                    begin
                        txs_r <= sfc_pkg::TXS_IDLE;
                        sent_once_r <= 1'b1;
                        elapsed_r <= 16'h0000;
                    end
                end
                default: txs_r <= sfc_pkg::TXS_IDLE;
            endcase
        end
    end

    // mac may start a new data frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_start_ok <= 1'b0;
            paused <= 1'b0;
        end
        else
        begin
            paused <= timer_r != 16'h0000;
            tx_start_ok <= timer_r == 16'h0000
                && !(fdx && col_q)
                && txs_r == sfc_pkg::TXS_IDLE && !gen_busy;
        end
    end
endmodule
`default_nettype wire

// ### tb/sfc_link_partner.sv
// link partner: byte clock, rx frames, pause capture
`timescale 1ns/1ps
`default_nettype none
module sfc_link_partner (
    output logic link_clk,
    output logic rx_dv,
    output logic [7:0] rx_data,
    output logic port_receive_error,
    output logic col,
    input wire logic [7:0] pfr_data,
    input wire logic pfr_valid
);
    logic [7:0] fr [0:1599];
    logic [7:0] got [$];
    int n_tx = 0, idx = 0;
    logic err_at = 1'b0;
    initial
    begin
        {link_clk, rx_dv, port_receive_error, col, rx_data} = 12'h000;
        #3;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge link_clk)
        if (pfr_valid)
            got.push_back(pfr_data);
    // idle data toggles
    always @(negedge link_clk)
    begin
        rx_dv <= idx < n_tx;
        rx_data <= idx < n_tx ? fr[idx] : ~rx_data;
        port_receive_error <= err_at && idx == 20;
        if (idx < n_tx)
            idx <= idx + 1;
    end
    function automatic logic [31:0] fcs(input int n);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < n; i++)
        begin
            c = c ^ {24'h000000, fr[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return ~c;
    endfunction
    // fcs goes low byte first; bad flips one bit
    task automatic send(input int n, input logic bad, input logic err);
        logic [31:0] c;
        c = fcs(n - 4) ^ {31'h0, bad};
        for (int i = 0; i < 4; i++)
            fr[n - 4 + i] = c[8 * i +: 8];
        err_at = err;
        idx = 0;
        n_tx = n;
        repeat (n + 7) @(negedge link_clk);
    endtask
endmodule
`default_nettype wire

// ### tb/sfc_flow_ctl_properties.sv
// port checks for flow control
`timescale 1ns/1ps
`default_nettype none
module sfc_flow_ctl_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_dv,
    input wire logic tx_start_ok,
    input wire logic [7:0] pfr_data,
    input wire logic pfr_valid,
    input wire logic rx_ctrl_drop,
    input wire logic paused
);
    int vcnt;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            vcnt <= 0;
        else
            vcnt <= pfr_valid ? vcnt + 1 : 0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("late pready");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("long pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("stray read data");
    frame_len_a: assert property ($fell(pfr_valid) |-> vcnt >= 630 && vcnt <= 650)
        else $error("bad frame length");
    first_byte_a: assert property ($rose(pfr_valid) |-> pfr_data == 8'h01)
        else $error("bad first byte");
    byte_hold_a: assert property (pfr_valid && $changed(pfr_data) |=> ($stable(pfr_data) || !pfr_valid) [*8])
        else $error("short byte");
    paused_block_a: assert property (paused ##1 paused |-> !tx_start_ok)
        else $error("start while paused");
    pause_hold_a: assert property ($rose(paused) |=> paused [*8])
        else $error("early expiry");
    drop_end_a: assert property ($fell(rx_dv) |-> ##[1:10] !rx_ctrl_drop)
        else $error("drop flag stuck");
    cover property ($fell(pfr_valid));
    cover property ($rose(paused));
    cover property (pready && pslverr);
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench top for flow control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [47:0] DA = 48'h0180C2000001;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mac_tx_busy = 0, e;
    logic [7:0] paddr = 8'h00, rx_data, pfr_data;
    logic [31:0] pwdata = 32'h0, prdata, q, c;
    logic pready, pslverr, link_clk, rx_dv, port_receive_error, col, tx_start_ok, force_col;
    logic pfr_valid, rx_ctrl_drop, pause_req_n, txp_req_n, rxp_req_n, paused;
    logic [11:0] free_buffers = 12'hFFF;
    logic [47:0] node;
    logic [7:0] nc [2] = '{8'h1B, 8'h0A};
    int fail_count = 0, num_checks = 0, t, pt, n;
    longint t0;
    always #4 pclk = ~pclk;
    sfc_flow_ctl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .free_buffers(free_buffers), .link_clk(link_clk), .rx_dv(rx_dv), .rx_data(rx_data),
        .port_receive_error(port_receive_error), .col(col), .mac_tx_busy(mac_tx_busy),
        .tx_start_ok(tx_start_ok), .force_col(force_col), .pfr_data(pfr_data), .pfr_valid(pfr_valid),
        .rx_ctrl_drop(rx_ctrl_drop), .pause_req_n(pause_req_n), .txp_req_n(txp_req_n),
        .rxp_req_n(rxp_req_n), .paused(paused));
    sfc_link_partner P (.link_clk(link_clk), .rx_dv(rx_dv), .rx_data(rx_data),
        .port_receive_error(port_receive_error), .col(col), .pfr_data(pfr_data), .pfr_valid(pfr_valid));
    task automatic stop_test();
        $display("checks %0d bad %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tmo(input string nm);
        $display("BAD %s exp done got timeout", nm);
        fail_count++;
        stop_test();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50)
            tmo("pready");
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, x);
    endtask
    function automatic logic sg(input int s);
        return s == 0 ? pfr_valid : s == 1 ? paused : force_col;
    endfunction
    task automatic wt(input int s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && sg(s) !== v; k++)
            @(posedge pclk);
        if (k == lim)
            tmo($sformatf("signal %0d", s));
    endtask
    task automatic hold(input int s, input logic v, input int lim, input string nm);
        int k = 0;
        repeat (lim)
        begin
            @(posedge pclk);
            if (sg(s) !== v)
                k++;
        end
        chk(nm, 32'(k), 32'h0);
    endtask
    task automatic mk(input logic [47:0] da, input logic [15:0] op, input logic [15:0] v, input int len);
        logic [143:0] h;
        h = {da, node, 16'h8808, op, v};
        for (int i = 0; i < len - 4; i++)
            P.fr[i] = i < 18 ? h[143 - 8 * i -: 8] : 8'h00;
    endtask
    initial
    begin
        t = $urandom(32'hE6F48460);
        node = 48'({$urandom, $urandom});
        pt = 5 * $urandom_range(2, 1);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("req_n", 32'({pause_req_n, txp_req_n, rxp_req_n}), 32'h7);
        rd(sfc_pkg::A_CTRL, 32'hE0);
        rd(sfc_pkg::A_THRESH, 32'h288);
        for (int w = 0; w < 2; w++)
        begin
            apb(w[0], 8'h20, 32'hFFFFFFFF);
            chk("slverr", 32'(e), 32'h1);
        end
        wr(sfc_pkg::A_CTRL_CNT, 32'h5);
        rd(sfc_pkg::A_CTRL_CNT, 32'h0);
        wr(sfc_pkg::A_NODE_LO, node[31:0]);
        wr(sfc_pkg::A_NODE_HI, 32'(node[47:32]));
        rd(sfc_pkg::A_NODE_HI, 32'(node[47:32]));
        wr(sfc_pkg::A_PT10, 32'(pt));
        wr(sfc_pkg::A_PT100, 32'h0);
        wr(sfc_pkg::A_CTRL, 32'h01);
        chk("req_n", 32'({pause_req_n, txp_req_n, rxp_req_n}), 32'h0);
        free_buffers <= 12'($urandom_range(647, 0));
        wt(2, 1'b1, 20);
        hold(2, 1'b1, 2000, "force_col");
        free_buffers <= 12'h288;
        hold(2, 1'b1, 20, "force_col");
        free_buffers <= 12'h289;
        wt(2, 1'b0, 20);
        free_buffers <= 12'h000;
        for (int i = 0; i < 2; i++)
        begin
            wr(sfc_pkg::A_CTRL, 32'(nc[i]));
            hold(0, 1'b0, 300, "pfr_valid");
        end
        mac_tx_busy <= 1'b1;
        P.col <= 1'b1;
        wr(sfc_pkg::A_CTRL, 32'h0B);
        hold(0, 1'b0, 200, "pfr_valid");
        mac_tx_busy <= 1'b0;
        hold(0, 1'b0, 200, "pfr_valid");
        P.got.delete();
        P.col <= 1'b0;
        wt(0, 1'b1, 100);
        t0 = $time;
        mk(DA, 16'h0001, 16'h0014, 64);
        P.send(64, 1'b0, 1'b0);
        chk("paused", 32'(paused), 32'h1);
        chk("tx_start_ok", 32'(tx_start_ok), 32'h0);
        wt(0, 1'b0, 800);
        mk(DA, 16'h0001, 16'(pt), 64);
        c = P.fcs(60);
        chk("bytes", 32'(P.got.size()), 32'h40);
        for (int i = 0; i < 64; i++)
            chk("byte", 32'(P.got[i]), 32'(i < 60 ? P.fr[i] : c[8 * (i - 60) +: 8]));
        wt(0, 1'b1, 9000);
        t = int'(($time - t0) / 8);
        n = (pt - pt / 5) * 640;
        chk("resend", 32'(t >= n - 100 && t <= n + 800), 32'h1);
        chk("paused", 32'(paused), 32'h1);
        free_buffers <= 12'hFFF;
        wr(sfc_pkg::A_CTRL, 32'h08);
        wt(1, 1'b0, 20);
        wt(0, 1'b0, 800);
        wr(sfc_pkg::A_CTRL, 32'h04);
        for (int k = 0; k < 6; k++)
        begin
            n = k == 3 ? 63 : k == 4 ? 1532 : k == 5 ? 1531 : 64;
            mk(DA, k == 0 ? 16'h0002 : 16'h0001, 16'h0003, n);
            P.send(n, k == 1, k == 2);
            chk("paused", 32'(paused), 32'(k == 5));
            rd(sfc_pkg::A_CTRL_CNT, 32'(k + 2));
        end
        for (t = 0; t < 3000 && paused === 1'b1; t++)
            @(posedge pclk);
        chk("pause_len", 32'(t > 1150 && t < 1950), 32'h1);
        for (int j = 0; j < 2; j++)
        begin
            mk(DA, 16'h0001, 16'h0064, 64);
            P.send(64, 1'b0, 1'b0);
            chk("paused", 32'(paused), 32'h1);
            mk(j ? 48'h020000000001 : DA, 16'h0001, j ? 16'h0032 : 16'h0000, 64);
            P.send(64, 1'b0, 1'b0);
            chk("paused", 32'(paused), 32'h0);
        end
        stop_test();
    end
endmodule
bind sfc_flow_ctl sfc_flow_ctl_properties chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_dv(rx_dv),
    .tx_start_ok(tx_start_ok), .pfr_data(pfr_data), .pfr_valid(pfr_valid),
    .rx_ctrl_drop(rx_ctrl_drop), .paused(paused));
`default_nettype wire
